// file: hw/elcc_regs.vh
`ifndef ELCC_REGS_VH
`define ELCC_REGS_VH
// Register map (addresses are register numbers)
`define ELCC_LSTS_BASE  8'h20
`define ELCC_CFG_BASE   8'h80
`define ELCC_STAT_BASE  8'ha0
`define ELCC_BASE_MASK  8'hf8
// Link configuration fields
`define ELCC_B_EN       31
`define ELCC_B_WIDE     30
`define ELCC_B_ERR      27
`define ELCC_B_ISSUED   26
`define ELCC_B_HELD     25
`define ELCC_B_INIT     24
`define ELCC_B_RXRST    23
`define ELCC_F_TGAP     21:11
`define ELCC_F_KGAP     10:0
// Static forwarding and link status fields
`define ELCC_B_FWD      31
`define ELCC_F_CHAN     4:0
`define ELCC_B_JUNK     2
// Widths
`define ELCC_GAP_W      11
`define ELCC_CHAN_W     5
`define ELCC_TOK_W      9
`define ELCC_WIRES      5
`define ELCC_LINKS      8
`define ELCC_B_CTRL     8
// Control tokens
`define ELCC_TOK_END    9'h101
`define ELCC_TOK_GREET  9'h102
`define ELCC_TOK_CREDIT 9'h103
// Symbols per token in each mode
`define ELCC_SYMS_2W    4'h9
`define ELCC_SYMS_5W    4'h5
// Reset values
`define ELCC_ZERO32     32'h0000_0000
`endif

// file: hw/elcc_link_engine.v
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "elcc_regs.vh"
module elcc_link_engine (
	input  wire                    clk_in,
	input  wire                    rst_n_in,
	input  wire                    en_in,
	input  wire                    wide_in,
	input  wire [`ELCC_GAP_W-1:0]  tgap_in,
	input  wire [`ELCC_GAP_W-1:0]  kgap_in,
	input  wire                    init_in,
	input  wire                    rxrst_in,
	input  wire [`ELCC_WIRES-1:0]  rx_pin_in,
	input  wire                    tx_valid_in,
	input  wire [`ELCC_TOK_W-1:0]  tx_data_in,
	output wire                    tx_ready_out,
	output wire [`ELCC_WIRES-1:0]  tx_pin_out,
	output wire                    rx_valid_out,
	output wire [`ELCC_TOK_W-1:0]  rx_data_out,
	output wire                    bad_out,
	output wire                    held_out,
	output wire                    issued_out
);
	// One-hot transmit states
	localparam ST_IDLE = 3'h1;
	localparam ST_SYM  = 3'h2;
	localparam ST_GAP  = 3'h4;

	reg [`ELCC_WIRES-1:0] s1_reg, s2_reg, s3_reg; // Pin synchroniser
	reg [`ELCC_WIRES-1:0] stable_reg;             // Last settled wire levels
	reg [9:0]             rxsh_reg;               // Receive symbol shifter
	reg [3:0]             rxcnt_reg;              // Symbols received so far
	reg                   rxv_reg, bad_reg;       // Receive pulses
	reg [`ELCC_TOK_W-1:0] rxd_reg;                // Received token
	reg [2:0]             state_reg;              // Transmit state
	reg [9:0]             txsh_reg;               // Transmit symbol shifter
	reg [3:0]             txcnt_reg;              // Symbols still to send
	reg [`ELCC_GAP_W-1:0] gap_reg;                // Pacing counter
	reg [`ELCC_WIRES-1:0] txpin_reg;              // Wire levels driven out
	reg                   greet_reg, credit_reg;  // Control tokens waiting
	reg                   dpend_reg;              // Data token waiting
	reg [`ELCC_TOK_W-1:0] data_reg;               // Waiting data token
	reg                   held_reg, issued_reg;   // Credit state
	reg                   ready_reg;              // Ready to take data

	////////////////////////////////////////////////////////////////////////////////
	// Receive symbol decode
	wire [`ELCC_WIRES-1:0] chg = (s2_reg == s3_reg) ? (s3_reg ^ stable_reg) : {`ELCC_WIRES{1'b0}};
	wire onehot = (chg != {`ELCC_WIRES{1'b0}}) && ((chg & (chg - 5'h01)) == {`ELCC_WIRES{1'b0}});
	wire legal  = onehot && !chg[4] && (wide_in || chg[3:2] == 2'h0);
	wire [1:0] sv = wide_in ? {chg[3] | chg[2], chg[3] | chg[1]} : {1'b0, chg[1]};
	wire [9:0] rxsh_next = wide_in ? {sv, rxsh_reg[9:2]} : {sv[0], rxsh_reg[9:1]};
	wire [3:0] syms = wide_in ? `ELCC_SYMS_5W : `ELCC_SYMS_2W;
	wire       last = (rxcnt_reg + 4'h1) == syms;
	wire [`ELCC_TOK_W-1:0] tok = wide_in ? rxsh_next[8:0] : rxsh_next[9:1];
	wire       padbad = wide_in && rxsh_next[9];
	wire       sym_ok = en_in && legal;
	wire       done = sym_ok && last;
	wire       got_credit = done && !padbad && tok == `ELCC_TOK_CREDIT;
	wire       got_greet  = done && !padbad && tok == `ELCC_TOK_GREET;
	wire       take = tx_valid_in && ready_reg;
	// Transmit symbol as one toggled wire
	wire [`ELCC_WIRES-1:0] tsym = wide_in ? (5'h01 << txsh_reg[1:0]) : (5'h01 << txsh_reg[0]);

	////////////////////////////////////////////////////////////////////////////////
	// Receiver
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s1_reg <= 5'h00;
			s2_reg <= 5'h00;
			s3_reg <= 5'h00;
			stable_reg <= 5'h00;
			rxsh_reg <= 10'h000;
			rxcnt_reg <= 4'h0;
			rxv_reg <= 1'b0;
			bad_reg <= 1'b0;
			rxd_reg <= 9'h000;
		end
		else
		begin
			s1_reg <= rx_pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				stable_reg <= s3_reg;
			rxv_reg <= 1'b0;
			bad_reg <= en_in && ((chg != 5'h00 && !legal) || (done && padbad));
			if (!en_in || rxrst_in)
			begin
				// Next symbol starts a fresh token
				rxcnt_reg <= 4'h0;
				rxsh_reg <= 10'h000;
			end
			else if (sym_ok)
			begin
				rxsh_reg <= last ? 10'h000 : rxsh_next;
				rxcnt_reg <= last ? 4'h0 : rxcnt_reg + 4'h1;
				// Data and end tokens go to the switch side
				if (done && !padbad && !got_credit && !got_greet)
				begin
					rxv_reg <= 1'b1;
					rxd_reg <= tok;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter and credit state
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= ST_IDLE;
			txsh_reg <= 10'h000;
			txcnt_reg <= 4'h0;
			gap_reg <= 11'h000;
			txpin_reg <= 5'h00;
			greet_reg <= 1'b0;
			credit_reg <= 1'b0;
			dpend_reg <= 1'b0;
			data_reg <= 9'h000;
			held_reg <= 1'b0;
			issued_reg <= 1'b0;
			ready_reg <= 1'b0;
		end
		else if (!en_in)
		begin
			// Disabled link drops pending tokens and credit state
			state_reg <= ST_IDLE;
			txpin_reg <= 5'h00;
			greet_reg <= 1'b0;
			credit_reg <= 1'b0;
			dpend_reg <= 1'b0;
			held_reg <= 1'b0;
			issued_reg <= 1'b0;
			ready_reg <= 1'b0;
		end
		else
		begin
			// Credit arriving beats a same-cycle init
			if (got_credit)
				held_reg <= 1'b1;
			else if (init_in)
				held_reg <= 1'b0;
			if (got_greet)
				credit_reg <= 1'b1;
			if (take)
			begin
				dpend_reg <= 1'b1;
				data_reg <= tx_data_in;
			end
			ready_reg <= held_reg && !dpend_reg && !take;
			case (state_reg)
				ST_IDLE:
				begin
					txcnt_reg <= syms;
					gap_reg <= 11'h000;
					// Greeting first, then credit, then data
					if (greet_reg || init_in)
					begin
						greet_reg <= 1'b0;
						txsh_reg <= {1'b0, `ELCC_TOK_GREET};
						state_reg <= ST_SYM;
					end
					else if (credit_reg)
					begin
						credit_reg <= got_greet;
						issued_reg <= 1'b1;
						txsh_reg <= {1'b0, `ELCC_TOK_CREDIT};
						state_reg <= ST_SYM;
					end
					else if (dpend_reg && held_reg)
					begin
						dpend_reg <= 1'b0;
						txsh_reg <= {1'b0, data_reg};
						state_reg <= ST_SYM;
					end
				end
				ST_SYM:
				begin
					if (init_in)
						greet_reg <= 1'b1;
					if (gap_reg == 11'h000)
					begin
						txpin_reg <= txpin_reg ^ tsym;
						txsh_reg <= wide_in ? {2'h0, txsh_reg[9:2]} : {1'b0, txsh_reg[9:1]};
						txcnt_reg <= txcnt_reg - 4'h1;
						if (txcnt_reg == 4'h1)
						begin
							gap_reg <= kgap_in;
							state_reg <= ST_GAP;
						end
						else
							gap_reg <= tgap_in;
					end
					else
						gap_reg <= gap_reg - 11'h001;
				end
				ST_GAP:
				begin
					if (init_in)
						greet_reg <= 1'b1;
					if (gap_reg == 11'h000)
						state_reg <= ST_IDLE;
					else
						gap_reg <= gap_reg - 11'h001;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	assign tx_ready_out = ready_reg;
	assign tx_pin_out   = txpin_reg;
	assign rx_valid_out = rxv_reg;
	assign rx_data_out  = rxd_reg;
	assign bad_out      = bad_reg;
	assign held_out     = held_reg;
	assign issued_out   = issued_reg;
endmodule
`default_nettype wire

// file: hw/elcc_top.v
// Overview of operation
// - Per-link enable bit, clear at reset, selects muxing
// - Mode bit: 0 two-wire, 1 five-wire
// - Overflow or bad token sets error; read clears
// - Status shows credit issued to far end
// - Status shows credit held for sending
// - Init write clears credit held (not credit issued), sends greeting token
// - Receiver reset realigns to next token start
// - Clocks between transitions within a token
// - Clocks between consecutive sent tokens
// - Registers serve links C,D,A,B,G,H,E,F order
// - Static link forwards all packets, no routing
// - Five-bit field picks destination channel end
// - Unroutable packet flagged junk and discarded
`timescale 1ns/100ps
`default_nettype none
`include "elcc_regs.vh"
module elcc_top (
	input  wire        REF_CLK_IN,
	input  wire        RST_N_IN,
	input  wire [7:0]  REG_ADDR_IN,
	input  wire [31:0] REG_WDATA_IN,
	input  wire        REG_WR_IN,
	input  wire        REG_RD_IN,
	output wire [31:0] REG_RDATA_OUT,
	input  wire [39:0] LINK_RX_IN,
	output wire [39:0] LINK_TX_OUT,
	output wire [7:0]  LINK_PINSEL_OUT,
	input  wire [7:0]  TX_VALID_IN,
	input  wire [71:0] TX_DATA_IN,
	output wire [7:0]  TX_READY_OUT,
	output wire        FWD_VALID_OUT,
	output wire [4:0]  FWD_CHANEND_OUT,
	output wire [8:0]  FWD_DATA_OUT,
	output wire [2:0]  FWD_LINK_OUT
);
	localparam NL = `ELCC_LINKS;
	localparam GW = `ELCC_GAP_W;
	localparam TW = `ELCC_TOK_W;
	localparam CW = `ELCC_CHAN_W;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	// True when the address falls in an eight-register bank
	function bank_hit;
		input [7:0] addr;
		input [7:0] base;
		begin
			bank_hit = (addr & `ELCC_BASE_MASK) == base;
		end
	endfunction

	// Index of lowest set bit, or zero
	function [2:0] lowest;
		input [NL-1:0] v;
		integer k;
		begin
			lowest = 3'h0;
			for (k = NL - 1; k >= 0; k = k - 1)
				if (v[k])
					lowest = k[2:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State
	reg [NL-1:0]    en_reg;      // Link enables
	reg [NL-1:0]    wide_reg;    // Five-wire mode
	reg [NL*GW-1:0] tgap_reg;    // Transition spacing per link
	reg [NL*GW-1:0] kgap_reg;    // Token spacing per link
	reg [NL-1:0]    init_reg;    // Init pulses to engines
	reg [NL-1:0]    rxrst_reg;   // Receiver reset pulses
	reg [NL-1:0]    fwd_reg;     // Static forwarding enables
	reg [NL*CW-1:0] chan_reg;    // Destination channel ends
	reg [NL-1:0]    err_reg;     // Sticky error flags
	reg [NL-1:0]    junk_reg;    // Junk packet flags
	reg [NL-1:0]    slotv_reg;   // Token waiting to forward
	reg [NL*TW-1:0] slotd_reg;   // Waiting tokens
	reg [31:0]      rdata_reg;   // Read data
	reg             fv_reg;      // Forward valid
	reg [CW-1:0]    fch_reg;     // Forward channel end
	reg [TW-1:0]    fd_reg;      // Forward token
	reg [2:0]       fl_reg;      // Forward link index
	reg [31:0]      rd_next;     // Read mux result

	wire [NL-1:0]    ready_w;    // Engine ready
	wire [NL-1:0]    rxv_w;      // Engine received token
	wire [NL*TW-1:0] rxd_w;      // Engine token data
	wire [NL-1:0]    bad_w;      // Engine illegal token
	wire [NL-1:0]    held_w;     // Engine credit held
	wire [NL-1:0]    issued_w;   // Engine credit issued

	// Register index selects the link in the fixed order
	wire [2:0] idx    = REG_ADDR_IN[2:0];
	wire       wr_cfg = REG_WR_IN && bank_hit(REG_ADDR_IN, `ELCC_CFG_BASE);
	wire       wr_st  = REG_WR_IN && bank_hit(REG_ADDR_IN, `ELCC_STAT_BASE);
	wire       rd_cfg = REG_RD_IN && bank_hit(REG_ADDR_IN, `ELCC_CFG_BASE);
	wire [2:0] pop    = lowest(slotv_reg);
	wire       popv   = slotv_reg != {NL{1'b0}};

	////////////////////////////////////////////////////////////////////////////////
	// Link engines, one per link
	genvar g;
	generate
		for (g = 0; g < NL; g = g + 1)
		begin : eng
			elcc_link_engine u_eng (
				.clk_in       (REF_CLK_IN),
				.rst_n_in     (RST_N_IN),
				.en_in        (en_reg[g]),
				.wide_in      (wide_reg[g]),
				.tgap_in      (tgap_reg[g*GW +: GW]),
				.kgap_in      (kgap_reg[g*GW +: GW]),
				.init_in      (init_reg[g]),
				.rxrst_in     (rxrst_reg[g]),
				.rx_pin_in    (LINK_RX_IN[g*5 +: 5]),
				.tx_valid_in  (TX_VALID_IN[g]),
				.tx_data_in   (TX_DATA_IN[g*TW +: TW]),
				.tx_ready_out (ready_w[g]),
				.tx_pin_out   (LINK_TX_OUT[g*5 +: 5]),
				.rx_valid_out (rxv_w[g]),
				.rx_data_out  (rxd_w[g*TW +: TW]),
				.bad_out      (bad_w[g]),
				.held_out     (held_w[g]),
				.issued_out   (issued_w[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Read mux; reserved and unmapped bits read zero
	always @*
	begin
		rd_next = `ELCC_ZERO32;
		if (bank_hit(REG_ADDR_IN, `ELCC_CFG_BASE))
		begin
			rd_next[`ELCC_B_EN]     = en_reg[idx];
			rd_next[`ELCC_B_WIDE]   = wide_reg[idx];
			rd_next[`ELCC_B_ERR]    = err_reg[idx];
			rd_next[`ELCC_B_ISSUED] = issued_w[idx];
			rd_next[`ELCC_B_HELD]   = held_w[idx];
			rd_next[`ELCC_F_TGAP]   = tgap_reg[idx*GW +: GW];
			rd_next[`ELCC_F_KGAP]   = kgap_reg[idx*GW +: GW];
		end
		else if (bank_hit(REG_ADDR_IN, `ELCC_STAT_BASE))
		begin
			rd_next[`ELCC_B_FWD]  = fwd_reg[idx];
			rd_next[`ELCC_F_CHAN] = chan_reg[idx*CW +: CW];
		end
		else if (bank_hit(REG_ADDR_IN, `ELCC_LSTS_BASE))
			rd_next[`ELCC_B_JUNK] = junk_reg[idx];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes, flags and static forwarding
	integer i;
	always @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			en_reg <= 8'h00;
			wide_reg <= 8'h00;
			tgap_reg <= {NL*GW{1'b0}};
			kgap_reg <= {NL*GW{1'b0}};
			init_reg <= 8'h00;
			rxrst_reg <= 8'h00;
			fwd_reg <= 8'h00;
			chan_reg <= {NL*CW{1'b0}};
			err_reg <= 8'h00;
			junk_reg <= 8'h00;
			slotv_reg <= 8'h00;
			slotd_reg <= {NL*TW{1'b0}};
			rdata_reg <= `ELCC_ZERO32;
			fv_reg <= 1'b0;
			fch_reg <= 5'h00;
			fd_reg <= 9'h000;
			fl_reg <= 3'h0;
		end
		else
		begin
			// Read data stands for one cycle only
			rdata_reg <= REG_RD_IN ? rd_next : `ELCC_ZERO32;
			// Self-clearing command bits last one cycle
			init_reg <= 8'h00;
			rxrst_reg <= 8'h00;
			if (wr_cfg)
			begin
				en_reg[idx] <= REG_WDATA_IN[`ELCC_B_EN];
				wide_reg[idx] <= REG_WDATA_IN[`ELCC_B_WIDE];
				init_reg[idx] <= REG_WDATA_IN[`ELCC_B_INIT];
				rxrst_reg[idx] <= REG_WDATA_IN[`ELCC_B_RXRST];
				tgap_reg[idx*GW +: GW] <= REG_WDATA_IN[`ELCC_F_TGAP];
				kgap_reg[idx*GW +: GW] <= REG_WDATA_IN[`ELCC_F_KGAP];
			end
			if (wr_st)
			begin
				fwd_reg[idx] <= REG_WDATA_IN[`ELCC_B_FWD];
				chan_reg[idx*CW +: CW] <= REG_WDATA_IN[`ELCC_F_CHAN];
			end
			// Forward the lowest waiting token
			fv_reg <= popv;
			if (popv)
			begin
				fd_reg <= slotd_reg[pop*TW +: TW];
				fch_reg <= chan_reg[pop*CW +: CW];
				fl_reg <= pop;
			end
			for (i = 0; i < NL; i = i + 1)
			begin
				// Error set wins over the read that clears it
				if (bad_w[i] || (rxv_w[i] && fwd_reg[i] && slotv_reg[i] && !(popv && pop == i)))
					err_reg[i] <= 1'b1;
				else if (rd_cfg && idx == i)
					err_reg[i] <= 1'b0;
				if (popv && pop == i)
					slotv_reg[i] <= 1'b0;
				if (rxv_w[i] && fwd_reg[i] && !(slotv_reg[i] && !(popv && pop == i)))
				begin
					// Static link skips routing
					slotv_reg[i] <= 1'b1;
					slotd_reg[i*TW +: TW] <= rxd_w[i*TW +: TW];
					junk_reg[i] <= 1'b0;
				end
				else if (rxv_w[i] && !fwd_reg[i])
					// No route here: drop and flag until packet end
					junk_reg[i] <= rxd_w[i*TW +: TW] != `ELCC_TOK_END;
			end
		end
	end

	assign REG_RDATA_OUT   = rdata_reg;
	assign LINK_PINSEL_OUT = en_reg;
	assign TX_READY_OUT    = ready_w;
	assign FWD_VALID_OUT   = fv_reg;
	assign FWD_CHANEND_OUT = fch_reg;
	assign FWD_DATA_OUT    = fd_reg;
	assign FWD_LINK_OUT    = fl_reg;
endmodule
`default_nettype wire

// file: test/elcc_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "elcc_regs.vh"
// Watches the register port, the pins of link 0 and the forwarding outputs
module elcc_top_properties (
	input wire logic        REF_CLK_IN,
	input wire logic        RST_N_IN,
	input wire logic [7:0]  REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	input wire logic        REG_WR_IN,
	input wire logic        REG_RD_IN,
	input wire logic [31:0] REG_RDATA_OUT,
	input wire logic [39:0] LINK_TX_OUT,
	input wire logic [7:0]  LINK_PINSEL_OUT,
	input wire logic        FWD_VALID_OUT,
	input wire logic [4:0]  FWD_CHANEND_OUT,
	input wire logic [2:0]  FWD_LINK_OUT
);
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	logic [7:0] base;          // Region of the current address
	logic [4:0] chan_reg [8];  // Shadow of the destination fields
	logic [7:0] fwd_reg;       // Shadow of the forward enables
	assign base = REG_ADDR_IN & `ELCC_BASE_MASK;
	////////////////////////////////////////////////////////////////
	// Shadow the static settings from bus writes
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
		if (!RST_N_IN)
		begin
			fwd_reg <= 8'h00;
			for (int i = 0; i < 8; i++)
				chan_reg[i] <= 5'h00;
		end
		else if (REG_WR_IN && base == `ELCC_STAT_BASE)
		begin
			fwd_reg[REG_ADDR_IN[2:0]] <= REG_WDATA_IN[31];
			chan_reg[REG_ADDR_IN[2:0]] <= REG_WDATA_IN[4:0];
		end
	////////////////////////////////////////////////////////////////
	// Read data stand only in the cycle after a read
	a_rdata_idle: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0)
		else $error("read data not zero outside a read");
	a_resv_zero: assert property (REG_RDATA_OUT[29:28] == 2'h0 && REG_RDATA_OUT[24:22] == 3'h0)
		else $error("reserved or write-only bits read nonzero");
	a_static_resv: assert property (REG_RD_IN && base == `ELCC_STAT_BASE |=> REG_RDATA_OUT[30:5] == 26'h0)
		else $error("static register reserved bits nonzero");
	a_status_resv: assert property (REG_RD_IN && base == `ELCC_LSTS_BASE |=> (REG_RDATA_OUT & 32'hffff_fffb) == 0)
		else $error("status register holds more than junk bit");
	a_unmapped_zero: assert property (REG_RD_IN && base != `ELCC_LSTS_BASE && base != `ELCC_CFG_BASE
		&& base != `ELCC_STAT_BASE |=> REG_RDATA_OUT == 32'h0)
		else $error("unmapped read nonzero");
	// Pin select follows the enable bit of the written link
	a_pinsel_follow: assert property (REG_WR_IN && base == `ELCC_CFG_BASE |-> ##1
		LINK_PINSEL_OUT[$past(REG_ADDR_IN[2:0])] == $past(REG_WDATA_IN[31]))
		else $error("pin select does not follow enable");
	a_tx_quiet: assert property (!LINK_PINSEL_OUT[0] [*3] |-> LINK_TX_OUT[4:0] == 5'h00)
		else $error("disabled link drives wires");
	// Init on an idle link starts the greeting within a few cycles
	a_init_greet: assert property (REG_WR_IN && REG_ADDR_IN == `ELCC_CFG_BASE && REG_WDATA_IN[31]
		&& REG_WDATA_IN[24] && !LINK_PINSEL_OUT[0] |-> ##[1:4] LINK_TX_OUT[4:0] != $past(LINK_TX_OUT[4:0]))
		else $error("no greeting after init");
	a_fwd_chan: assert property (FWD_VALID_OUT |-> FWD_CHANEND_OUT == chan_reg[FWD_LINK_OUT])
		else $error("forwarded to wrong channel end");
	a_fwd_static: assert property (FWD_VALID_OUT |-> fwd_reg[FWD_LINK_OUT])
		else $error("forward from non-static link");
	c_fwd: cover property (FWD_VALID_OUT);
	c_err: cover property (REG_RD_IN && base == `ELCC_CFG_BASE ##1 REG_RDATA_OUT[27]);
	c_junk: cover property (REG_RD_IN && base == `ELCC_LSTS_BASE ##1 REG_RDATA_OUT[2]);
endmodule
`default_nettype wire

// file: test/elcc_far_node.sv
`timescale 1ns/100ps
`default_nettype none
`include "elcc_regs.vh"
// Remote switch node on one link, two-wire coding only
module elcc_far_node (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [4:0] tx_pin_in,
	output var  logic [4:0] rx_pin_out
);
	logic [4:0] prev_reg;   // Wires seen at the last edge
	logic [8:0] shift_reg;  // Token being gathered
	logic [3:0] nsym;       // Symbols gathered so far
	logic [8:0] last_tok;   // Last whole token
	logic       bit_now;    // Symbol value of this change
	int         tok_cnt;    // Tokens received
	int         greet_cnt;  // Greetings received
	int         since;      // Cycles since the last change
	int         last_tgap;  // Spacing inside a token
	int         last_kgap;  // Spacing between tokens
	int         replied;    // Greetings answered
	initial rx_pin_out = 5'h00;
	assign bit_now = tx_pin_in[1] ^ prev_reg[1];
	////////////////////////////////////////////////////////////////
	// Decode wire toggles into tokens, first symbol is bit 0
	always @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			prev_reg <= 5'h00;
			nsym <= 4'h0;
			tok_cnt <= 0;
			greet_cnt <= 0;
			since <= 1000;
		end
		else
		begin
			prev_reg <= tx_pin_in;
			since <= since + 1;
			if (tx_pin_in != prev_reg)
			begin
				since <= 1;
				if (nsym == 4'h0)
					last_kgap <= since;
				else
					last_tgap <= since;
				shift_reg <= {bit_now, shift_reg[8:1]};
				nsym <= (nsym == 4'h8) ? 4'h0 : nsym + 4'h1;
				if (nsym == 4'h8)
				begin
					last_tok <= {bit_now, shift_reg[8:1]};
					tok_cnt <= tok_cnt + 1;
					if ({bit_now, shift_reg[8:1]} == `ELCC_TOK_GREET)
						greet_cnt <= greet_cnt + 1;
				end
			end
		end
	////////////////////////////////////////////////////////////////
	// One symbol: toggle one wire, then hold it four cycles in all
	task automatic toggle(input int w);
		@(posedge clk_in);
		rx_pin_out[w] <= ~rx_pin_out[w];
		repeat (3) @(posedge clk_in);
	endtask
	// Send the first n symbols of a token
	task automatic send_token(input logic [8:0] tok, input int n);
		for (int i = 0; i < n; i++)
			toggle(int'(tok[i]));
	endtask
	// Answer every greeting with credit
	initial
	begin
		replied = 0;
		forever
		begin
			@(posedge clk_in);
			if (greet_cnt > replied)
			begin
				replied++;
				send_token(`ELCC_TOK_CREDIT, 9);
			end
		end
	end
endmodule
`default_nettype wire

// file: test/elcc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "elcc_regs.vh"
module elcc_top_tb;
	logic        REF_CLK_IN, RST_N_IN, REG_WR_IN, REG_RD_IN, FWD_VALID_OUT;
	logic [7:0]  REG_ADDR_IN, LINK_PINSEL_OUT, TX_VALID_IN, TX_READY_OUT;
	logic [31:0] REG_WDATA_IN, REG_RDATA_OUT, rv, v;
	logic [39:0] LINK_RX_IN, LINK_TX_OUT;
	logic [71:0] TX_DATA_IN;
	logic [4:0]  FWD_CHANEND_OUT, far_rx, fwd_chan;
	logic [8:0]  FWD_DATA_OUT, fwd_data;
	logic [2:0]  FWD_LINK_OUT, fwd_link;
	int          err_total, total_checks, fwd_cnt;
	assign LINK_RX_IN = {35'h0, far_rx};
	elcc_top uut (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
		.REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
		.LINK_RX_IN(LINK_RX_IN), .LINK_TX_OUT(LINK_TX_OUT), .LINK_PINSEL_OUT(LINK_PINSEL_OUT),
		.TX_VALID_IN(TX_VALID_IN), .TX_DATA_IN(TX_DATA_IN), .TX_READY_OUT(TX_READY_OUT),
		.FWD_VALID_OUT(FWD_VALID_OUT), .FWD_CHANEND_OUT(FWD_CHANEND_OUT), .FWD_DATA_OUT(FWD_DATA_OUT),
		.FWD_LINK_OUT(FWD_LINK_OUT));
	elcc_far_node u_far (.clk_in(REF_CLK_IN), .rst_n_in(RST_N_IN), .tx_pin_in(LINK_TX_OUT[4:0]), .rx_pin_out(far_rx));
	////////////////////////////////////////////////////////////////
	// Clock, 20 ns period
	initial
	begin
		REF_CLK_IN = 1'b0;
		forever #10 REF_CLK_IN = ~REF_CLK_IN;
	end
	// Capture every forwarded token
	always @(posedge REF_CLK_IN)
		if (FWD_VALID_OUT === 1'b1)
		begin
			fwd_cnt <= fwd_cnt + 1;
			fwd_data <= FWD_DATA_OUT;
			fwd_chan <= FWD_CHANEND_OUT;
			fwd_link <= FWD_LINK_OUT;
		end
	// Hang guard
	initial
	begin
		#400000;
		err_total++;
		report_and_stop();
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK_IN);
		REG_ADDR_IN <= a;
		REG_WDATA_IN <= d;
		REG_WR_IN <= 1'b1;
		@(posedge REF_CLK_IN);
		REG_WR_IN <= 1'b0;
	endtask
	// One-cycle read strobe, data taken in the next cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge REF_CLK_IN);
		REG_ADDR_IN <= a;
		REG_RD_IN <= 1'b1;
		@(posedge REF_CLK_IN);
		REG_RD_IN <= 1'b0;
		@(negedge REF_CLK_IN);
		d = REG_RDATA_OUT;
	endtask
	// Offer a data token on link 0 until it is taken; a stuck wait ends in the hang guard
	task automatic offer(input logic [8:0] tok);
		@(posedge REF_CLK_IN);
		TX_VALID_IN[0] <= 1'b1;
		TX_DATA_IN[8:0] <= tok;
		do
			@(posedge REF_CLK_IN);
		while (!TX_READY_OUT[0]);
		TX_VALID_IN[0] <= 1'b0;
	endtask
	// Wait until the far node has gathered n tokens
	task automatic wait_tok(input int n);
		while (u_far.tok_cnt < n)
			@(posedge REF_CLK_IN);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		{RST_N_IN, REG_WR_IN, REG_RD_IN, REG_ADDR_IN, REG_WDATA_IN, TX_VALID_IN, TX_DATA_IN} = 0;
		{err_total, total_checks, fwd_cnt} = 0;
		repeat (5) @(posedge REF_CLK_IN);
		RST_N_IN <= 1'b1;
		// Reset values, then each link register alone
		for (int i = 0; i < 8; i++)
		begin
			rd(8'h80 + 8'(i), rv);
			check("cfg reset", 32'h0, rv);
			rd(8'ha0 + 8'(i), rv);
			check("static reset", 32'h0, rv);
			rd(8'h20 + 8'(i), rv);
			check("status reset", 32'h0, rv);
			v = 32'hb040_0000 | (32'(i[0]) << 30) | (32'(i) << 11) | 32'(7 - i);
			wr(8'h80 + 8'(i), v);
			rd(8'h80 + 8'(i), rv);
			check("cfg rw", v & 32'hc03f_ffff, rv);
			check("pin select", 32'((2 << i) - 1), {24'h0, LINK_PINSEL_OUT});
			wr(8'ha0 + 8'(i), 32'h7fff_ffe0 | 32'(i + 8));
			rd(8'ha0 + 8'(i), rv);
			check("static rw", 32'(i + 8), rv);
		end
		wr(8'h55, 32'hffff_ffff);
		rd(8'h55, rv);
		check("unmapped", 32'h0, rv);
		// Bring up link 0: greeting out, credit back
		wr(8'h80, 32'h0);
		wr(8'ha0, 32'h8000_0013);
		wr(8'h80, 32'h8100_1805);
		wait_tok(1);
		check("greeting", `ELCC_TOK_GREET, 32'(u_far.last_tok));
		check("transition gap", 32'h4, u_far.last_tgap);
		repeat (60) @(posedge REF_CLK_IN);
		rd(8'h80, rv);
		check("credit held", 32'h8200_1805, rv);
		u_far.send_token(`ELCC_TOK_GREET, 9);
		wait_tok(2);
		check("credit answer", `ELCC_TOK_CREDIT, 32'(u_far.last_tok));
		repeat (5) @(posedge REF_CLK_IN);
		rd(8'h80, rv);
		check("credit issued", 32'h8600_1805, rv);
		// Two data tokens back to back; last symbol to next first symbol is the token gap plus three cycles
		offer(9'h0a5);
		offer(9'h03c);
		wait_tok(3);
		check("data 1", 32'h0a5, 32'(u_far.last_tok));
		wait_tok(4);
		check("data 2", 32'h03c, 32'(u_far.last_tok));
		check("token gap", 32'h8, u_far.last_kgap);
		// Link 1 holds no credit: offered data stays put, wires stay at reset level
		@(posedge REF_CLK_IN);
		TX_DATA_IN[17:9] <= 9'h0ff;
		TX_VALID_IN[1] <= 1'b1;
		repeat (100) @(posedge REF_CLK_IN);
		check("no credit tx", 32'h0, 32'(LINK_TX_OUT[9:5]));
		check("no credit ready", 32'h0, 32'(TX_READY_OUT[1]));
		TX_VALID_IN[1] <= 1'b0;
		rd(8'h81, rv);
		check("link 1 cfg", 32'hc000_0806, rv);
		// Static forwarding from link 0, issued credit allows far end data
		u_far.send_token(9'h05a, 9);
		repeat (10) @(posedge REF_CLK_IN);
		check("fwd data", 32'h05a, 32'(fwd_data));
		check("fwd chan", 32'h13, 32'(fwd_chan));
		check("fwd link", 32'h0, 32'(fwd_link));
		// Illegal wire toggle flags an error, cleared by reading
		u_far.toggle(2);
		repeat (10) @(posedge REF_CLK_IN);
		rd(8'h80, rv);
		check("error set", 32'h8e00_1805, rv);
		rd(8'h80, rv);
		check("error cleared", 32'h8600_1805, rv);
		// Half a token, receiver reset, then a whole token
		u_far.send_token(9'h0ff, 4);
		repeat (4) @(posedge REF_CLK_IN);
		wr(8'h80, 32'h8080_1805);
		u_far.send_token(9'h0c3, 9);
		repeat (10) @(posedge REF_CLK_IN);
		check("resync data", 32'h0c3, 32'(fwd_data));
		// Non-static link: data is junk, end token clears it
		wr(8'ha0, 32'h0);
		u_far.send_token(9'h066, 9);
		repeat (10) @(posedge REF_CLK_IN);
		rd(8'h20, rv);
		check("junk set", 32'h4, rv);
		u_far.send_token(`ELCC_TOK_END, 9);
		repeat (10) @(posedge REF_CLK_IN);
		rd(8'h20, rv);
		check("junk clear", 32'h0, rv);
		check("fwd count", 32'h2, fwd_cnt);
		report_and_stop();
	end
endmodule
bind elcc_top elcc_top_properties u_props (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
	.REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
	.LINK_TX_OUT(LINK_TX_OUT), .LINK_PINSEL_OUT(LINK_PINSEL_OUT), .FWD_VALID_OUT(FWD_VALID_OUT),
	.FWD_CHANEND_OUT(FWD_CHANEND_OUT), .FWD_LINK_OUT(FWD_LINK_OUT));
`default_nettype wire
